// ===== hw/emi_pkg.sv
package emi_pkg;
   // host port address width and data width
   localparam int          HOST_AW        = 8;
   localparam int          HOST_DW        = 8;
   // host-visible register indices
   localparam logic [7:0]  MNG_CTL_LO_IDX = 8'h00;
   localparam logic [7:0]  MNG_CTL_HI_IDX = 8'h01;
   localparam logic [7:0]  MNG_DAT_LO_IDX = 8'h02;
   localparam logic [7:0]  MNG_DAT_HI_IDX = 8'h03;
   // management control field positions (16-bit view)
   localparam int          CMD_FIN_BIT    = 14;
   localparam int          RW_BIT         = 13;
   localparam int          PHY_ADDR_MSB   = 12;
   localparam int          PHY_ADDR_LSB   = 8;
   localparam int          REG_ADDR_MSB   = 4;
   localparam int          REG_ADDR_LSB   = 0;
   localparam logic [15:0] MNG_CTL_RST    = 16'h0000;
   localparam logic [15:0] MNG_DAT_RST    = 16'h0000;
   // management clock divider (half period in core cycles)
   localparam logic [7:0]  MDC_HALF       = 8'h14;
   // management frame: 32 preamble + 14 header + 2 turn + 16 data
   localparam logic [6:0]  MF_LEN         = 7'h40;
   localparam logic [6:0]  MF_ADDR_END    = 7'h2e;
   // statistics vector width
   localparam int          TX_STAT_W      = 16;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01,
      TX_DONE = 2'b10,
      TX_ABRT = 2'b11
   } emi_tx_state_t;
endpackage

// ===== hw/emi_mac_if.sv
`timescale 1ns/1ps
// Functional notes
// R1: flag rx frame error to application when delivered frame had errors
// R2: on rx fifo overflow stop writing the current frame
// R3: raise rx fifo error on overflow, valid with rx end-of-frame
// R4: application raises frame-available when a full frame waits
// R5: after frame-available read and send bytes until tx end-of-frame
// R6: pulse tx statistics strobe with statistics vector after a frame
// R7: pulse tx done when a frame was sent successfully
// R8: drained together with end-of-frame on last byte: valid frame, done
// R9: drained mid-frame: stop reading, abandon, pulse discard indication
// R10: host write with cs, write low; device answers ready low
// R11: host read with cs, read low; ready and output enable low, data
// R12: management write keeps enable high and shifts every bit out
// R13: management read drives enable only during address, then releases
// R14: gmii tx data and enable driven on the tx clock
// R15: gmii tx error raised while sending an errored frame
// R16: gmii rx data and enable sampled on rising rx clock edge
// R17: gmii rx error marks the received frame as errored
// R18: fast mode uses reference clocks for tx and rx clocking
// R19: ignore control writes while busy; command-finished low while busy
// R20: phy and register address shifted msb first, five bits each
// R21: application strobes are single-cycle and registered
module emi_mac_if (
   input  wire logic                            core_clk_in,
   input  wire logic                            rst_in,
   // rx application side
   input  wire logic                            rx_fifo_full_in,
   output logic                                 rx_fifo_wr_out,
   output logic [7:0]                           rx_data_out,
   output logic                                 rx_eof_out,
   output logic                                 rx_error_out,
   output logic                                 rx_fifo_error_out,
   // tx application side
   input  wire logic                            tx_fifo_avail_in,
   input  wire logic [7:0]                      tx_fifo_data_in,
   input  wire logic                            tx_fifo_eof_in,
   input  wire logic                            tx_buffer_drained_in,
   input  wire logic                            tx_frame_bad_in,
   output logic                                 tx_fifo_rd_out,
   output logic                                 tx_done_out,
   output logic                                 tx_discard_out,
   output logic                                 tx_stat_en_out,
   output logic [emi_pkg::TX_STAT_W-1:0]        tx_stat_vec_out,
   // host port
   input  wire logic                            host_cs_n_in,
   input  wire logic                            host_wr_n_in,
   input  wire logic                            host_rd_n_in,
   input  wire logic [emi_pkg::HOST_AW-1:0]     host_addr_in,
   input  wire logic [emi_pkg::HOST_DW-1:0]     host_wdata_in,
   output logic                                 host_ready_n_out,
   output logic                                 host_rdata_oe_n_out,
   output logic [emi_pkg::HOST_DW-1:0]          host_rdata_out,
   // management serial port
   output logic                                 mng_clk_out,
   output logic                                 mng_do_out,
   output logic                                 mng_oe_out,
   input  wire logic                            mng_di_in,
   // gmii, transmit and receive clocked by core clock (reference clocks)
   output logic [7:0]                           gmii_txd_out,
   output logic                                 gmii_tx_en_out,
   output logic                                 gmii_tx_er_out,
   input  wire logic [7:0]                      gmii_rxd_in,
   input  wire logic                            gmii_rx_dv_in,
   input  wire logic                            gmii_rx_er_in
);
   import emi_pkg::*;

   typedef struct packed {
      // rx
      logic [7:0]  rxd_s1;
      logic        rxdv_s1;
      logic        rxer_s1;
      logic [7:0]  rxd_s2;
      logic        rxdv_s2;
      logic        rxer_s2;
      logic        rx_in_frame;
      logic        rx_err_acc;
      logic        rx_ovf_acc;
      logic        rx_wr;
      logic [7:0]  rx_data;
      logic        rx_eof;
      logic        rx_error;
      logic        rx_fifo_error;
      // tx
      emi_tx_state_t tx_state;
      logic        tx_rd;
      logic [7:0]  txd;
      logic        tx_en;
      logic        tx_er;
      logic        tx_bad;
      logic [15:0] tx_count;
      logic        tx_done;
      logic        tx_discard;
      logic        tx_stat_en;
      logic [15:0] tx_stat_vec;
      // host
      logic [2:0]  hs_cs;
      logic [2:0]  hs_wr;
      logic [2:0]  hs_rd;
      logic [15:0] hs_ad1;
      logic [15:0] hs_ad2;
      logic        h_ready_n;
      logic        h_oe_n;
      logic [7:0]  h_rdata;
      // management
      logic [15:0] mng_ctl;
      logic [15:0] mng_dat;
      logic        mng_busy;
      logic [7:0]  mdc_div;
      logic        mdc;
      logic [6:0]  mbit;
      logic [63:0] mshift;
      logic        mdi_s1;
      logic        mdi_s2;
   } emi_state_t;

   emi_state_t st_reg;
   emi_state_t st_next;

   // *************************************************************
   // register read decode
   // *************************************************************
   function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                           input logic [15:0] ctl,
                                           input logic [15:0] dat);
      logic [7:0] r;
      r = 8'h00;
      case (idx)
         MNG_CTL_LO_IDX: r = ctl[7:0];
         MNG_CTL_HI_IDX: r = ctl[15:8];
         MNG_DAT_LO_IDX: r = dat[7:0];
         MNG_DAT_HI_IDX: r = dat[15:8];
         default:        r = 8'h00;
      endcase
      return r;
   endfunction

   always_comb begin
      logic        h_wr_act;
      logic        h_rd_act;
      logic        mdc_rise;
      logic        mdc_fall;
      logic [15:0] ctl_wr;
      h_wr_act = 1'b0;
      h_rd_act = 1'b0;
      mdc_rise = 1'b0;
      mdc_fall = 1'b0;
      ctl_wr   = 16'h0000;
      st_next  = st_reg;

      // ***********************************************************
      // receive path
      // ***********************************************************
      st_next.rxd_s1  = gmii_rxd_in;           // see R16 R18
      st_next.rxdv_s1 = gmii_rx_dv_in;
      st_next.rxer_s1 = gmii_rx_er_in;
      st_next.rxd_s2  = st_reg.rxd_s1;
      st_next.rxdv_s2 = st_reg.rxdv_s1;
      st_next.rxer_s2 = st_reg.rxer_s1;
      st_next.rx_wr         = 1'b0;
      st_next.rx_eof        = 1'b0;
      st_next.rx_error      = 1'b0;
      st_next.rx_fifo_error = 1'b0;
      if (st_reg.rxdv_s2) begin
         st_next.rx_in_frame = 1'b1;
         if (st_reg.rxer_s2) begin
            st_next.rx_err_acc = 1'b1;         // see R17
         end
         if (rx_fifo_full_in || st_reg.rx_ovf_acc) begin
            st_next.rx_ovf_acc = 1'b1;         // see R2
         end else begin
            st_next.rx_wr   = 1'b1;            // see R21
            st_next.rx_data = st_reg.rxd_s2;
         end
      end else if (st_reg.rx_in_frame) begin
         // end of frame marker, with flags qualified alongside
         st_next.rx_in_frame   = 1'b0;
         st_next.rx_eof        = 1'b1;
         st_next.rx_error      = st_reg.rx_err_acc;   // see R1
         st_next.rx_fifo_error = st_reg.rx_ovf_acc;   // see R3
         st_next.rx_err_acc    = 1'b0;
         st_next.rx_ovf_acc    = 1'b0;
      end

      // ***********************************************************
      // transmit path
      // ***********************************************************
      st_next.tx_rd      = 1'b0;
      st_next.tx_done    = 1'b0;
      st_next.tx_discard = 1'b0;
      st_next.tx_stat_en = 1'b0;
      case (st_reg.tx_state)
         TX_IDLE: begin
            st_next.tx_en = 1'b0;
            st_next.tx_er = 1'b0;
            if (tx_fifo_avail_in && !tx_buffer_drained_in) begin
               st_next.tx_state = TX_SEND;     // see R5
               st_next.tx_rd    = 1'b1;
               st_next.tx_count = 16'h0000;
               st_next.tx_bad   = 1'b0;
            end
         end
         TX_SEND: begin
            // byte requested last cycle is on the data input now
            st_next.txd      = tx_fifo_data_in;    // see R14
            st_next.tx_en    = 1'b1;
            st_next.tx_er    = tx_frame_bad_in;    // see R15
            st_next.tx_bad   = st_reg.tx_bad | tx_frame_bad_in;
            st_next.tx_count = st_reg.tx_count + 16'h0001;
            if (tx_fifo_eof_in) begin
               st_next.tx_state = TX_DONE;     // see R8
            end else if (tx_buffer_drained_in) begin
               st_next.tx_state = TX_ABRT;     // see R9
               st_next.tx_en    = 1'b0;
               st_next.tx_er    = 1'b0;
            end else begin
               st_next.tx_rd = 1'b1;
            end
         end
         TX_DONE: begin
            st_next.tx_en       = 1'b0;
            st_next.tx_er       = 1'b0;
            st_next.tx_done     = !st_reg.tx_bad;    // see R7
            st_next.tx_stat_en  = 1'b1;              // see R6
            st_next.tx_stat_vec = st_reg.tx_count;
            st_next.tx_state    = TX_IDLE;
         end
         TX_ABRT: begin
            st_next.tx_er      = 1'b0;
            st_next.tx_discard = 1'b1;               // see R9
            st_next.tx_state   = TX_IDLE;
         end
         default: st_next.tx_state = TX_IDLE;
      endcase

      // ***********************************************************
      // host port
      // ***********************************************************
      st_next.hs_cs = {st_reg.hs_cs[1:0], ~host_cs_n_in};
      st_next.hs_wr = {st_reg.hs_wr[1:0], ~host_wr_n_in};
      st_next.hs_rd = {st_reg.hs_rd[1:0], ~host_rd_n_in};
      st_next.hs_ad1 = {host_addr_in, host_wdata_in};
      st_next.hs_ad2 = st_reg.hs_ad1;
      if (st_reg.hs_cs[1] && st_reg.hs_wr[1] && !st_reg.hs_wr[2]) begin
         h_wr_act = 1'b1;
      end
      if (st_reg.hs_cs[1] && st_reg.hs_rd[1] && !st_reg.hs_rd[2]) begin
         h_rd_act = 1'b1;
      end
      if (!st_reg.hs_cs[1]) begin
         st_next.h_ready_n = 1'b1;
         st_next.h_oe_n    = 1'b1;
      end
      if (h_wr_act) begin
         st_next.h_ready_n = 1'b0;             // see R10
         ctl_wr = st_reg.mng_ctl;
         case (st_reg.hs_ad2[15:8])
            MNG_CTL_LO_IDX: ctl_wr[7:0]  = st_reg.hs_ad2[7:0];
            MNG_CTL_HI_IDX: ctl_wr[15:8] = st_reg.hs_ad2[7:0];
            MNG_DAT_LO_IDX: st_next.mng_dat[7:0]  = st_reg.hs_ad2[7:0];
            MNG_DAT_HI_IDX: st_next.mng_dat[15:8] = st_reg.hs_ad2[7:0];
            default: ;
         endcase
         if (!st_reg.mng_busy && (st_reg.hs_ad2[15:8] == MNG_CTL_LO_IDX ||
                                  st_reg.hs_ad2[15:8] == MNG_CTL_HI_IDX)) begin
            st_next.mng_ctl = ctl_wr;          // see R19
            st_next.mng_ctl[CMD_FIN_BIT] = 1'b0;
            st_next.mng_ctl[15] = 1'b0;
            st_next.mng_ctl[7:5] = 3'b000;
            // a write to the upper byte launches the transfer
            if (st_reg.hs_ad2[15:8] == MNG_CTL_HI_IDX) begin
               st_next.mng_busy = 1'b1;
               st_next.mbit     = 7'h00;
               st_next.mshift   = {32'hffffffff, 2'b01,
                  ctl_wr[RW_BIT] ? 2'b01 : 2'b10,
                  ctl_wr[PHY_ADDR_MSB:PHY_ADDR_LSB],     // see R20
                  ctl_wr[REG_ADDR_MSB:REG_ADDR_LSB],
                  2'b10, st_reg.mng_dat};
            end
         end
      end
      if (h_rd_act) begin
         st_next.h_ready_n = 1'b0;             // see R11
         st_next.h_oe_n    = 1'b0;
         st_next.h_rdata   = reg_read(st_reg.hs_ad2[15:8], st_reg.mng_ctl,
                                      st_reg.mng_dat);
      end

      // ***********************************************************
      // management serial engine
      // ***********************************************************
      st_next.mdi_s1 = mng_di_in;
      st_next.mdi_s2 = st_reg.mdi_s1;
      if (st_reg.mng_busy) begin
         st_next.mng_ctl[CMD_FIN_BIT] = 1'b0;    // see R19
         if (st_reg.mdc_div == MDC_HALF - 8'h01) begin
            st_next.mdc_div = 8'h00;
            st_next.mdc     = ~st_reg.mdc;
            mdc_rise = ~st_reg.mdc;
            mdc_fall = st_reg.mdc;
         end else begin
            st_next.mdc_div = st_reg.mdc_div + 8'h01;
         end
         if (mdc_fall && st_reg.mbit != 7'h00) begin
            st_next.mshift = {st_reg.mshift[62:0], 1'b0};
         end
         if (mdc_rise) begin
            if (!st_reg.mng_ctl[RW_BIT] &&
                st_reg.mbit > MF_ADDR_END + 7'h01) begin
               st_next.mng_dat = {st_reg.mng_dat[14:0], st_reg.mdi_s2};
            end
            st_next.mbit = st_reg.mbit + 7'h01;
         end
         // finish on the fall after the last bit was clocked
         if (mdc_fall && st_reg.mbit == MF_LEN) begin
            st_next.mng_busy = 1'b0;
            st_next.mng_ctl[CMD_FIN_BIT] = 1'b1;
         end
      end else begin
         st_next.mdc_div = 8'h00;
         st_next.mdc     = 1'b0;
      end

      if (rst_in) begin
         st_next = '0;
         st_next.tx_state  = TX_IDLE;
         st_next.h_ready_n = 1'b1;
         st_next.h_oe_n    = 1'b1;
         st_next.mng_ctl   = MNG_CTL_RST;
         st_next.mng_dat   = MNG_DAT_RST;
      end
   end

   always_ff @(posedge core_clk_in) begin
      st_reg <= st_next;
   end

   // *************************************************************
   // outputs
   // *************************************************************
   assign rx_fifo_wr_out      = st_reg.rx_wr;
   assign rx_data_out         = st_reg.rx_data;
   assign rx_eof_out          = st_reg.rx_eof;
   assign rx_error_out        = st_reg.rx_error;
   assign rx_fifo_error_out   = st_reg.rx_fifo_error;
   assign tx_fifo_rd_out      = st_reg.tx_rd;
   assign tx_done_out         = st_reg.tx_done;
   assign tx_discard_out      = st_reg.tx_discard;
   assign tx_stat_en_out      = st_reg.tx_stat_en;
   assign tx_stat_vec_out     = st_reg.tx_stat_vec;
   assign host_ready_n_out    = st_reg.h_ready_n;
   assign host_rdata_oe_n_out = st_reg.h_oe_n;
   assign host_rdata_out      = st_reg.h_rdata;
   assign mng_clk_out         = st_reg.mdc;
   assign mng_do_out          = st_reg.mng_busy & st_reg.mshift[63];
   // read frames release the line after the address field
   assign mng_oe_out          = st_reg.mng_busy &
      (st_reg.mng_ctl[RW_BIT] || st_reg.mbit <= MF_ADDR_END);  // see R12 R13
   assign gmii_txd_out        = st_reg.txd;                    // see R14 R18
   assign gmii_tx_en_out      = st_reg.tx_en;
   assign gmii_tx_er_out      = st_reg.tx_er;
endmodule

// ===== tb/emi_mac_if_assertions.sv
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module emi_mac_if_assertions (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic rx_fifo_full_in,
   input wire logic rx_fifo_wr_out,
   input wire logic rx_eof_out,
   input wire logic rx_error_out,
   input wire logic rx_fifo_error_out,
   input wire logic tx_fifo_rd_out,
   input wire logic tx_done_out,
   input wire logic tx_discard_out,
   input wire logic tx_stat_en_out,
   input wire logic host_cs_n_in,
   input wire logic host_ready_n_out,
   input wire logic host_rdata_oe_n_out,
   input wire logic gmii_tx_en_out,
   input wire logic gmii_tx_er_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   a_rx_err_eof: assert property (rx_error_out |-> rx_eof_out)
      else $error("rx error flag without end of frame");
   a_rx_ovf_eof: assert property (rx_fifo_error_out |-> rx_eof_out)
      else $error("rx overflow flag without end of frame");
   a_rx_full_stop: assert property (
      rx_fifo_full_in [*3] |=> !rx_fifo_wr_out)
      else $error("rx write while fifo full");
   a_done_stat: assert property (tx_done_out |-> tx_stat_en_out)
      else $error("tx done without statistics strobe");
   a_done_single: assert property (tx_done_out |=> !tx_done_out)
      else $error("tx done longer than one cycle");
   a_discard_alone: assert property (
      tx_discard_out |-> !tx_done_out && !tx_stat_en_out && !tx_fifo_rd_out)
      else $error("discard together with done, stat or read");
   a_ready_cause: assert property (
      !host_ready_n_out |-> !$past(host_cs_n_in, 3))
      else $error("host ready without chip select");
   a_rdoe_ready: assert property (
      !host_rdata_oe_n_out |-> !host_ready_n_out)
      else $error("read enable without ready");
   a_txer_frame: assert property (gmii_tx_er_out |-> gmii_tx_en_out)
      else $error("tx error outside frame");
   a_txen_after_rd: assert property (
      $rose(gmii_tx_en_out) |-> $past(tx_fifo_rd_out))
      else $error("tx enable without fifo read");
   c_done: cover property (tx_done_out);
   c_discard: cover property (tx_discard_out);
   c_ovf: cover property (rx_fifo_error_out);
   c_read: cover property (!host_rdata_oe_n_out);
endmodule

// ===== tb/emi_tx_app_model.sv
`timescale 1ns/1ps
// ****************
// tx fifo and management line model
// ****************
module emi_tx_app_model (
   input  wire logic       core_clk_in,
   input  wire logic       avail_in,
   input  wire logic       rd_in,
   input  wire logic [7:0] len_in,
   input  wire logic [7:0] abort_at_in,
   input  wire logic [7:0] bad_at_in,
   input  wire logic       mng_do_in,
   input  wire logic       mng_oe_in,
   output logic [7:0]      data_out,
   output logic            eof_out,
   output logic            drained_out,
   output logic            bad_out,
   output logic            mng_di_out
);
   logic [7:0] idx_reg;
   // show-ahead: head byte stands, a read pops it
   assign data_out = idx_reg + 8'h40;
   assign eof_out  = (idx_reg == len_in - 8'h01);
   assign bad_out  = (idx_reg == bad_at_in);
   // empty from the last byte on, or past the abort point
   assign drained_out = !avail_in || idx_reg >= len_in - 8'h01
                        || idx_reg > abort_at_in;
   // pull-up on the shared management line
   assign mng_di_out = mng_oe_in ? mng_do_in : 1'b1;
   always @(posedge core_clk_in) begin
      if (!avail_in) begin
         idx_reg <= 8'h00;
      end else if (rd_in) begin
         idx_reg <= idx_reg + 8'h01;
      end
   end
endmodule

// ===== tb/emi_mac_if_tb.sv
`timescale 1ns/1ps
module emi_mac_if_tb;
   import emi_pkg::*;
   logic                 core_clk_in, rst_in, rx_fifo_full_in;
   logic                 rx_fifo_wr_out, rx_eof_out, rx_error_out;
   logic                 rx_fifo_error_out, tx_fifo_avail_in, tx_fifo_eof_in;
   logic                 tx_buffer_drained_in, tx_frame_bad_in;
   logic                 tx_fifo_rd_out, tx_done_out, tx_discard_out;
   logic                 tx_stat_en_out, host_cs_n_in, host_wr_n_in;
   logic                 host_rd_n_in, host_ready_n_out, host_rdata_oe_n_out;
   logic                 mng_clk_out, mng_do_out, mng_oe_out, mng_di_in;
   logic                 gmii_tx_en_out, gmii_tx_er_out;
   logic                 gmii_rx_dv_in, gmii_rx_er_in;
   logic [7:0]           rx_data_out, tx_fifo_data_in, host_addr_in;
   logic [7:0]           host_wdata_in, host_rdata_out, gmii_txd_out;
   logic [7:0]           gmii_rxd_in, len, abort_at, bad_at, q;
   logic [TX_STAT_W-1:0] tx_stat_vec_out;
   int                   err_total, check_count;

   emi_mac_if uut (.core_clk_in, .rst_in, .rx_fifo_full_in, .rx_fifo_wr_out,
      .rx_data_out, .rx_eof_out, .rx_error_out, .rx_fifo_error_out,
      .tx_fifo_avail_in, .tx_fifo_data_in, .tx_fifo_eof_in,
      .tx_buffer_drained_in, .tx_frame_bad_in, .tx_fifo_rd_out, .tx_done_out,
      .tx_discard_out, .tx_stat_en_out, .tx_stat_vec_out, .host_cs_n_in,
      .host_wr_n_in, .host_rd_n_in, .host_addr_in, .host_wdata_in,
      .host_ready_n_out, .host_rdata_oe_n_out, .host_rdata_out, .mng_clk_out,
      .mng_do_out, .mng_oe_out, .mng_di_in, .gmii_txd_out, .gmii_tx_en_out,
      .gmii_tx_er_out, .gmii_rxd_in, .gmii_rx_dv_in, .gmii_rx_er_in);
   emi_tx_app_model app (.core_clk_in, .avail_in(tx_fifo_avail_in),
      .rd_in(tx_fifo_rd_out), .len_in(len), .abort_at_in(abort_at),
      .bad_at_in(bad_at), .mng_do_in(mng_do_out), .mng_oe_in(mng_oe_out),
      .data_out(tx_fifo_data_in), .eof_out(tx_fifo_eof_in),
      .drained_out(tx_buffer_drained_in), .bad_out(tx_frame_bad_in),
      .mng_di_out(mng_di_in));

   int          mdc_rises = 0, oe_cnt = 0;
   logic        mdc_prev = 1'b0;
   logic [63:0] mdo_sh = '0;
   // management clocks, enable cycles and the bit seen on each rise
   always @(negedge core_clk_in) begin
      mdc_prev <= mng_clk_out;
      oe_cnt   <= oe_cnt + int'(mng_oe_out === 1'b1);
      if (mng_clk_out === 1'b1 && mdc_prev === 1'b0) begin
         mdc_rises <= mdc_rises + 1;
         mdo_sh    <= {mdo_sh[62:0], mng_do_out};
      end
   end

   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ****************
   // host port access
   // ****************
   task automatic host_xfer(input logic wr, input logic [7:0] a, d);
      int i;
      @(negedge core_clk_in);
      host_cs_n_in = 1'b0;
      host_wr_n_in = !wr;
      host_rd_n_in = wr;
      host_addr_in = a;
      host_wdata_in = d;
      for (i = 0; i < 20 && host_ready_n_out !== 1'b0; i++)
         @(negedge core_clk_in);
      check(i < 20, "host ready missing");
      if (!wr) check(host_rdata_oe_n_out === 1'b0, "read oe");
      q = host_rdata_out;
      host_cs_n_in = 1'b1;
      host_wr_n_in = 1'b1;
      host_rd_n_in = 1'b1;
      for (i = 0; i < 20 && host_ready_n_out !== 1'b1; i++)
         @(negedge core_clk_in);
      check(i < 20, "host ready stuck");
   endtask

   task automatic host_regs;
      host_xfer(0, MNG_CTL_LO_IDX, 8'h00);
      check(q === MNG_CTL_RST[7:0], "ctl reset value");
      host_xfer(1, MNG_DAT_LO_IDX, 8'ha5);
      host_xfer(1, MNG_DAT_HI_IDX, 8'h3c);
      host_xfer(0, MNG_DAT_LO_IDX, 8'h00);
      check(q === 8'ha5, "data lo readback");
      host_xfer(0, MNG_DAT_HI_IDX, 8'h00);
      check(q === 8'h3c, "data hi readback");
   endtask

   // ****************
   // scenarios
   // ****************
   task automatic run_tx(input logic [7:0] n, ab, bd, input logic good, abt);
      int rds, ens, dn, ds, st, ers, tail;
      logic [15:0] sv;
      logic [7:0] first;
      {rds, ens, dn, ds, st, ers, tail} = '0;
      sv = '0;
      first = 8'h00;
      len = n;
      abort_at = ab;
      bad_at = bd;
      @(negedge core_clk_in);
      tx_fifo_avail_in = 1'b1;
      for (int i = 0; i < 400 && tail < 6; i++) begin
         @(negedge core_clk_in);
         if (gmii_tx_en_out === 1'b1 && ens == 0) first = gmii_txd_out;
         rds += tx_fifo_rd_out;
         ens += gmii_tx_en_out;
         ers += gmii_tx_er_out;
         dn += tx_done_out;
         ds += tx_discard_out;
         if (tx_stat_en_out === 1'b1) sv = tx_stat_vec_out;
         st += tx_stat_en_out;
         if (dn + ds + st > 0) tail++;
      end
      tx_fifo_avail_in = 1'b0;
      if (abt) begin
         check(ds == 1 && dn == 0 && st == 0, "abort strobes");
         check(rds < n, "reading went on after drain");
      end else if (good) begin
         check(dn == 1 && st == 1 && ds == 0, "done strobes");
         check(sv === {8'h00, n}, "stat vector");
         check(rds == n && ens == n, "byte counts");
         check(first === 8'h40 && ers == 0, "first byte");
      end else begin
         check(dn == 0 && st == 1 && ers > 0, "errored frame");
      end
   endtask

   task automatic run_rx(input int n, er_at, full_at, input logic e, o);
      int wr, eofs, ers, ovs, bad;
      {wr, eofs, ers, ovs, bad} = '0;
      for (int i = 0; i < n + 12; i++) begin
         @(negedge core_clk_in);
         if (rx_fifo_wr_out === 1'b1) begin
            if (rx_data_out !== wr[7:0]) bad++;
            wr++;
         end
         eofs += rx_eof_out;
         ers += rx_error_out;
         ovs += rx_fifo_error_out;
         gmii_rx_dv_in = (i < n);
         gmii_rxd_in = (i < n) ? i[7:0] : ~gmii_rxd_in;
         gmii_rx_er_in = (i == er_at);
         rx_fifo_full_in = (i < n) && (i >= full_at);
      end
      check(eofs == 1 && bad == 0, "rx frame bytes");
      check(ers == int'(e), "rx error flag");
      check(ovs == int'(o), "rx overflow flag");
      check(o ? (wr > 0 && wr < n) : wr == n, "rx write count");
   endtask

   task automatic run_mng(input logic rw);
      int oe, rs, fr, ad;
      logic [45:0] hd;
      fr = int'(MF_LEN) * 2 * int'(MDC_HALF);
      ad = int'(MF_ADDR_END) * 2 * int'(MDC_HALF);
      hd = {32'hffffffff, 2'b01, rw ? 2'b01 : 2'b10, 5'h15, 5'h0b};
      oe = oe_cnt;
      rs = mdc_rises;
      host_xfer(1, MNG_CTL_LO_IDX, 8'h0b);
      host_xfer(1, MNG_CTL_HI_IDX, {2'b00, rw, 5'h15});
      host_xfer(1, MNG_CTL_LO_IDX, 8'h1f);
      host_xfer(0, MNG_CTL_HI_IDX, 8'h00);
      check(q[CMD_FIN_BIT-8] === 1'b0, "finished while busy");
      repeat (fr + 200) @(negedge core_clk_in);
      oe = oe_cnt - oe;
      host_xfer(0, MNG_CTL_LO_IDX, 8'h00);
      check(q === 8'h0b, "busy write not ignored");
      host_xfer(0, MNG_CTL_HI_IDX, 8'h00);
      check(q === {2'b01, rw, 5'h15}, "finished flag");
      check(mdc_rises - rs == int'(MF_LEN), "mng clock count");
      check(mdo_sh[63:18] === hd, "mng header bits");
      if (rw) begin
         check(oe > fr - 120, "write enable span");
         check(mdo_sh[17:0] === {2'b10, 16'h3ca5}, "mng data bits");
      end else begin
         check(oe > ad - 120 && oe < ad + 120, "read enable span");
         host_xfer(0, MNG_DAT_LO_IDX, 8'h00);
         check(q === 8'hff, "released line reads high");
      end
   endtask

   initial begin
      core_clk_in = 1'b0;
      forever #2.5 core_clk_in = ~core_clk_in;
   end

   initial begin
      #200000;
      err_total++;
      print_verdict();
   end

   initial begin
      {err_total, check_count} = '0;
      {rst_in, host_cs_n_in, host_wr_n_in, host_rd_n_in} = 4'hf;
      {rx_fifo_full_in, tx_fifo_avail_in, gmii_rx_dv_in, gmii_rx_er_in} = '0;
      {host_addr_in, host_wdata_in, gmii_rxd_in} = '0;
      {len, abort_at, bad_at} = '0;
      repeat (8) @(negedge core_clk_in);
      rst_in = 1'b0;
      host_regs();
      run_tx(8'h40, 8'hff, 8'hff, 1'b1, 1'b0);
      run_tx(8'h40, 8'h14, 8'hff, 1'b0, 1'b1);
      run_tx(8'h10, 8'hff, 8'h05, 1'b0, 1'b0);
      run_rx(64, -1, 999, 1'b0, 1'b0);
      run_rx(64, 10, 999, 1'b1, 1'b0);
      run_rx(64, -1, 20, 1'b0, 1'b1);
      run_mng(1'b1);
      run_mng(1'b0);
      print_verdict();
   end
endmodule

bind emi_mac_if emi_mac_if_assertions u_chk (.core_clk_in, .rst_in,
   .rx_fifo_full_in, .rx_fifo_wr_out, .rx_eof_out, .rx_error_out,
   .rx_fifo_error_out, .tx_fifo_rd_out, .tx_done_out, .tx_discard_out,
   .tx_stat_en_out, .host_cs_n_in, .host_ready_n_out, .host_rdata_oe_n_out,
   .gmii_tx_en_out, .gmii_tx_er_out);
